// [hdl/ifm_top.sv]
// Purpose: two-wire serial slave in front of a 2048 x 8 byte array
// Assumes: bus master drives i_scl; pin wire level resolved outside
// Notes:   byte logic runs on i_scl; framing is seen on i_clk
//
// Summary of operation
// - 2048 bytes, 11-bit byte address
// - write each byte once fully received
// - never busy; next transaction may follow
// - sample on scl rise, shift on fall
// - data pin only pulled low or released
// - guard high blocks every array write
// - guard low allows writes everywhere
// - works at 100k, 400k, up to 1M
// - first byte: type, page, direction bit
// - write sends low address byte; reads don't
// - address steps before ack, wraps to zero
// - read continues on ack, stops on nack

`timescale 1ns/1ns
`default_nettype none

module ifm_top #(
  parameter logic [ifm_pkg::TYPE_W-1:0] DEV_TYPE = 4'h5  // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_wp,
  output logic o_frame
);

  import ifm_pkg::*;

  // ************************************************************
  // core clock domain: framing
  // ************************************************************
  ifm_line_s line_raw;
  ifm_line_s line_f;
  ifm_line_s line_prev;
  logic start_det;
  logic stop_det;
  logic armed;
  logic link_clr;
  logic por_hold;
  logic wp_core;

  // one driver for the whole carrier, so no tool sees split drivers
  assign line_raw = '{scl: i_scl, sda: i_sda_i};

  // both lines share one filter so their skew is kept
  ifm_sync #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_line_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(line_raw),
    .o_level(line_f)
  );

  // guard pin; reset value keeps writes blocked until sampled
  ifm_sync #(
    .W(1),
    .RST_VAL(WP_RST)
  ) u_wp_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_wp),
    .o_level(wp_core)
  );

  // previous filtered sample for edge finding
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      line_prev <= '{scl: 1'h1, sda: 1'h1};
    else
      line_prev <= line_f;
  end

  // start: data falls while clock high; stop: data rises while clock high
  assign start_det = line_prev.scl & line_f.scl & line_prev.sda & ~line_f.sda;
  assign stop_det = line_prev.scl & line_f.scl & ~line_prev.sda & line_f.sda;

  // power-on hold for the address latch in the link domain
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      por_hold <= 1'h1;
    else
      por_hold <= 1'h0;
  end

  // filter latency is a few core cycles, far below SCL_HALF_CYC
  // link_clr holds the link logic cleared from stop (or any start)
  // until the clock falls after a start; release lands in the low
  // phase, so no rising edge races it even at the top rate
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      link_clr <= 1'h1;
      armed <= 1'h0;
    end
    else if (start_det)
    begin
      link_clr <= 1'h1;
      armed <= 1'h1;
    end
    else if (stop_det)
    begin
      link_clr <= 1'h1;
      armed <= 1'h0;
    end
    else if (armed && !line_f.scl)
    begin
      link_clr <= 1'h0;
      armed <= 1'h0;
    end
  end

  // frame flag for the system side
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      o_frame <= 1'h0;
    else if (start_det)
      o_frame <= 1'h1;
    else if (stop_det)
      o_frame <= 1'h0;
  end

  // the pad never drives high; only the enable moves
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      o_sda_o <= 1'h0;
    else
      o_sda_o <= 1'h0;
  end

  // ************************************************************
  // link clock domain: byte engine
  // ************************************************************
  logic [BYTE_W-1:0] mem [MEM_DEPTH];
  logic [CNT_W-1:0] bit_cnt;
  logic [BYTE_W-1:0] shreg;
  logic [BYTE_W-1:0] rx_byte;
  logic [BYTE_W-1:0] tx_byte;
  logic [ADDR_W-1:0] addr;
  logic [2:0] tx_idx;
  ifm_state_e state;
  logic ack_pend;
  logic byte_done;
  logic at_ack;
  logic dev_match;
  logic is_read;
  logic wp_x1;
  logic wp_link;

  // guard level into the link domain; only moves while clocked,
  // so a change is seen two link edges later
  always_ff @(posedge i_scl or posedge por_hold)
  begin
    if (por_hold)
    begin
      wp_x1 <= WP_RST;
      wp_link <= WP_RST;
    end
    else
    begin
      wp_x1 <= wp_core;
      wp_link <= wp_x1;
    end
  end

  // byte being completed on this rising edge
  assign rx_byte = {shreg[BYTE_W-2:0], i_sda_i};
  assign byte_done = (bit_cnt == BIT_LAST);
  assign at_ack = (bit_cnt == BIT_ACK);
  // type field, then page, then direction
  assign dev_match = (rx_byte[TYPE_MSB:TYPE_LSB] == DEV_TYPE);
  assign is_read = rx_byte[RW_BIT];
  assign tx_idx = BIT_LAST[2:0] - bit_cnt[2:0];

  // shift in on rising edges; nine slots per byte
  always_ff @(posedge i_scl or posedge link_clr)
  begin
    if (link_clr)
    begin
      bit_cnt <= BIT_ZERO;
      shreg <= BYTE_ZERO;
    end
    else if (at_ack)
      bit_cnt <= BIT_ZERO;
    else
    begin
      bit_cnt <= bit_cnt + BIT_ONE;
      shreg <= rx_byte;
    end
  end

  // transaction state and acknowledge decision
  always_ff @(posedge i_scl or posedge link_clr)
  begin
    if (link_clr)
    begin
      state <= ST_DEVADR;
      ack_pend <= 1'h0;
    end
    else if (byte_done)
    begin
      case (state)
        ST_DEVADR:
        begin
          // other type codes leave the bus alone
          if (dev_match)
          begin
            ack_pend <= 1'h1;
            state <= is_read ? ST_RDATA : ST_WORD;
          end
          else
          begin
            ack_pend <= 1'h0;
            state <= ST_IGNORE;
          end
        end
        ST_WORD:
        begin
          ack_pend <= 1'h1;
          state <= ST_WDATA;
        end
        ST_WDATA:
          // acked even when the guard is on
          ack_pend <= 1'h1;
        ST_RDATA:
          ack_pend <= 1'h0;
        ST_IGNORE:
          ack_pend <= 1'h0;
        default:
        begin
          ack_pend <= 1'h0;
          state <= ST_IGNORE;
        end
      endcase
    end
    else if (at_ack)
    begin
      ack_pend <= 1'h0;
      // high in the ack slot ends the read
      if (state == ST_RDATA && i_sda_i)
        state <= ST_IGNORE;
    end
  end

  // address latch survives frames; cleared only at power-on
  always_ff @(posedge i_scl or posedge por_hold)
  begin
    if (por_hold)
      addr <= ADDR_RST;
    else if (byte_done)
    begin
      case (state)
        ST_DEVADR:
          // reads keep the low byte, page is taken on every type match
          if (dev_match)
            addr[ADDR_W-1:ADDR_PAGE_LSB] <= rx_byte[PAGE_MSB:PAGE_LSB];
        ST_WORD:
          addr[ADDR_LOW_MSB:0] <= rx_byte;
        // step before the ack slot, roll over
        ST_WDATA:
          addr <= ifm_addr_next(addr);
        ST_RDATA:
          addr <= ifm_addr_next(addr);
        default:
          addr <= addr;
      endcase
    end
  end

  // byte array; written on the edge that completes the byte
  // guard high blocks; guard low lets every address through
  // the write is done in one edge, so nothing is ever busy
  always_ff @(posedge i_scl)
  begin
    if (!link_clr && byte_done && state == ST_WDATA && !wp_link)
      mem[addr] <= rx_byte;
  end

  // next read byte fetched in the ack slot, after the address step
  always_ff @(posedge i_scl or posedge link_clr)
  begin
    if (link_clr)
      tx_byte <= BYTE_ZERO;
    else if (at_ack)
      tx_byte <= mem[addr];
  end

  // enable high pulls low; released otherwise
  always_ff @(negedge i_scl or posedge link_clr)
  begin
    if (link_clr)
      o_sda_oe <= 1'h0;
    else if (at_ack)
      o_sda_oe <= ack_pend;
    else if (state == ST_RDATA)
      o_sda_oe <= ~tx_byte[tx_idx];
    else
      o_sda_oe <= 1'h0;
  end

endmodule // ifm_top

`default_nettype wire

// [pkg/ifm_pkg.sv]
// Purpose: shared constants, types and helpers for the two-wire memory slave
// Assumes: 11-bit byte address, 8-bit data, MSB first on the wire
// Notes:   the device type code is a module parameter, not a constant here

package ifm_pkg;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int MEM_DEPTH = 2048;
  localparam int ADDR_W = 11;
  localparam int BYTE_W = 8;
  localparam int PAGE_W = 3;
  localparam int TYPE_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 11'h7FF;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

  // ************************************************************
  // first byte field layout
  // ************************************************************
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int PAGE_MSB = 3;
  localparam int PAGE_LSB = 1;
  localparam int RW_BIT = 0;
  localparam int ADDR_PAGE_LSB = 8;
  localparam int ADDR_LOW_MSB = 7;

  // ************************************************************
  // bit counter inside one byte slot
  // ************************************************************
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] BIT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] BIT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] BIT_LAST = 4'h7;
  localparam logic [CNT_W-1:0] BIT_ACK = 4'h8;

  // ************************************************************
  // reset values and link rates
  // ************************************************************
  localparam logic WP_RST = 1'h1;
  localparam int CLK_KHZ = 250000;
  localparam int SCL_STD_KHZ = 100;
  localparam int SCL_FAST_KHZ = 400;
  localparam int SCL_TOP_KHZ = 1000;
  // shortest half period of the link clock, in core cycles (rounded down)
  localparam int SCL_HALF_CYC = CLK_KHZ / (2 * SCL_TOP_KHZ);

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [4:0] {
    ST_DEVADR = 5'h01,
    ST_WORD   = 5'h02,
    ST_WDATA  = 5'h04,
    ST_RDATA  = 5'h08,
    ST_IGNORE = 5'h10
  } ifm_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } ifm_line_s;

  // sequential address step with roll-over at the top location
  function automatic logic [ADDR_W-1:0] ifm_addr_next(input logic [ADDR_W-1:0] a);
    ifm_addr_next = (a == ADDR_MAX) ? ADDR_RST : a + ADDR_ONE;
  endfunction

endpackage

// [hdl/ifm_sync.sv]
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to i_clk
// Notes:   output only moves when stages two and three agree

`timescale 1ns/1ns
`default_nettype none

module ifm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);

  logic [W-1:0] st1;
  logic [W-1:0] st2;
  logic [W-1:0] st3;

  // ************************************************************
  // stage chain; st1 feeds st2 only
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      st1 <= RST_VAL;
      st2 <= RST_VAL;
      st3 <= RST_VAL;
    end
    else
    begin
      st1 <= i_async;
      st2 <= st1;
      st3 <= st2;
    end
  end

  // per bit: take st2 when it matches st3, otherwise hold
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      o_level <= RST_VAL;
    else
      o_level <= (~(st2 ^ st3) & st2) | ((st2 ^ st3) & o_level);
  end

endmodule // ifm_sync

`default_nettype wire

// [testbench/ifm_monitor.sv]
// Purpose: pin checks on the memory slave
// Assumes: only top ports visible
// Notes:   all checks sampled on the core clock
`timescale 1ns/1ns
`default_nettype none
module ifm_monitor (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda_i,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic i_wp,
  input wire logic o_frame
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // bus conditions as seen on the wire
  sequence start_s;
    $fell(i_sda_i) && i_scl;
  endsequence
  sequence stop_s;
    $rose(i_sda_i) && i_scl;
  endsequence
  // ********
  // checks
  // ********
  pull_only_a: assert property (!o_sda_o) else $error("pin driven high");
  rise_on_fall_a: assert property ($rose(o_sda_oe) |-> !i_scl && $past(i_scl)) else $error("late drive");
  drop_on_fall_a: assert property ($fell(o_sda_oe) && !i_scl |-> $past(i_scl)) else $error("late release");
  start_frame_a: assert property (start_s |-> ##[1:8] o_frame) else $error("start missed");
  stop_release_a: assert property (stop_s |-> ##[1:10] (!o_frame && !o_sda_oe)) else $error("stop missed");
  oe_stands_a: assert property ($changed(o_sda_oe) |=> $stable(o_sda_oe)[*8]) else $error("drive glitch");
  idle_quiet_a: assert property (!o_frame && !$past(o_frame, 2) |-> !o_sda_oe) else $error("idle drive");
  drive_in_frame_a: assert property ($rose(o_sda_oe) |-> o_frame) else $error("drive before start");
endmodule // ifm_monitor
bind ifm_top ifm_monitor u_mon (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(i_scl), .i_sda_i(i_sda_i),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_wp(i_wp), .o_frame(o_frame));
`default_nettype wire

// [testbench/ifm_master_model.sv]
// Purpose: behavioural two-wire bus master
// Assumes: 30 ns tick; clock parked high between frames
// Notes:   open-drain data; the bench resolves the wire
`timescale 1ns/1ns
`default_nettype none
module ifm_master_model (
  output logic o_scl,
  output logic o_sda_oe,
  input wire logic i_sda
);
  // tick; the bench may stretch it to run the link at slower rates
  time T = 30;
  // idle bus, nothing pulled
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic start;
    o_sda_oe = 1'b0;
    #T o_scl = 1'b1;
    #T o_sda_oe = 1'b1;
    #(2*T) o_scl = 1'b0;
    #T;
  endtask
  task automatic stop;
    o_sda_oe = 1'b1;
    #T o_scl = 1'b1;
    #T o_sda_oe = 1'b0;
    #T;
  endtask
  // data moves only while clock low, low time kept over 8 core cycles
  task automatic bit_x(input logic b, output logic s);
    o_sda_oe = !b;
    #T o_scl = 1'b1;
    #T s = i_sda;
    #T o_scl = 1'b0;
    #T;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(a, k);
  endtask
endmodule // ifm_master_model
`default_nettype wire

// [testbench/ifm_top_tb.sv]
// Purpose: self-checking bench for the memory slave
// Assumes: wired-AND data line with pull-up
// Notes:   seeded random data; a model array predicts reads
`timescale 1ns/1ns
`default_nettype none
module ifm_top_tb;
  import ifm_pkg::*;
  localparam logic [3:0] DT = 4'h5; // arbitrary type code
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp = 1'b0;
  logic m_scl, m_oe, s_o, s_oe, frame, k;
  logic [7:0] q;
  logic [10:0] a;
  logic [7:0] mem [MEM_DEPTH];
  int n_fail = 0;
  int comparisons = 0;
  int seed = 86;
  // pull-up wins unless someone pulls low
  wire sda = !(m_oe || (s_oe && !s_o));
  // core clock
  always #2 clk = !clk;
  ifm_top #(.DEV_TYPE(DT)) uut (.i_clk(clk), .i_rst_b(rst_b), .i_scl(m_scl), .i_sda_i(sda), .o_sda_o(s_o),
    .o_sda_oe(s_oe), .i_wp(wp), .o_frame(frame));
  ifm_master_model m (.o_scl(m_scl), .o_sda_oe(m_oe), .i_sda(sda));
  // ********
  // helpers
  // ********
  function automatic logic [10:0] nxt(input logic [10:0] x);
    return x + 11'h001;
  endfunction
  task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk1(input string s, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s exp %b got %b", s, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // write n random bytes from x; a guarded array keeps old data
  task automatic wr(input logic [10:0] x, input int n);
    logic [7:0] d;
    m.start;
    m.xfer({DT, x[10:8], 1'b0}, 1'b1, q, k);
    chk1("dev ack", 1'b0, k);
    m.xfer(x[7:0], 1'b1, q, k);
    chk1("word ack", 1'b0, k);
    repeat (n)
    begin
      d = 8'($random(seed));
      m.xfer(d, 1'b1, q, k);
      chk1("data ack", 1'b0, k);
      if (!wp)
        mem[x] = d;
      x = nxt(x);
    end
  endtask
  // read n bytes from the latched address (expected at x), nack on the last
  task automatic rdc(input logic [10:0] x, input int n);
    m.start;
    m.xfer({DT, x[10:8], 1'b1}, 1'b1, q, k);
    chk1("rd ack", 1'b0, k);
    for (int i = 1; i <= n; i++)
    begin
      m.xfer(8'hFF, 1'(i == n), q, k);
      chk8("rd data", mem[x], q);
      x = nxt(x);
    end
    m.stop;
  endtask
  // point at x, then read n bytes
  task automatic rd(input logic [10:0] x, input int n);
    wr(x, 0);
    rdc(x, n);
  endtask
  // hang guard
  initial
  begin
    #360000;
    n_fail++;
    $display("ERROR watchdog exp done got hang");
    conclude;
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    wr(11'h7FE, 3);
    m.stop;
    rd(11'h7FE, 3);
    @(posedge clk);
    #1 wp = 1'b1;
    wr(11'h7FE, 2);
    m.stop;
    // guarded bytes still step the latch: 7FEh plus two rolls to 000h
    rdc(11'h000, 1);
    rd(11'h7FE, 3);
    repeat (6)
    begin
      @(posedge clk);
      #1 wp = 1'b0;
      a = 11'($random(seed));
      wr(a, 4);
      m.stop;
      @(posedge clk);
      #1 wp = 1'($random(seed));
      wr(a, 4);
      m.stop;
      rd(a, 4);
    end
    // top link rate: a 250 ns tick gives a 1 MHz clock
    @(posedge clk);
    #1 wp = 1'b0;
    m.T = 250;
    wr(11'h123, 1);
    m.stop;
    rd(11'h123, 1);
    m.start;
    chk1("frame set", 1'b1, frame);
    m.xfer({~DT, 4'h0}, 1'b1, q, k);
    chk1("foreign ack", 1'b1, k);
    m.stop;
    repeat (4) @(posedge clk);
    #1;
    chk1("frame clear", 1'b0, frame);
    conclude;
  end
endmodule // ifm_top_tb
`default_nettype wire
